// *** verilog/dig_pkg.sv ***
package dig_pkg;
	// ==========================================================
	// register map (byte address, word index = address / 4)
	// ==========================================================
	localparam logic [7:0] REG_ROUTE     = 8'h00; // capture routing field
	localparam logic [7:0] REG_WATCHDOG  = 8'h04; // loaded watchdog settings
	localparam logic [7:0] REG_SUPPLY    = 8'h08; // regulator mode and monitor state
	localparam logic [7:0] REG_REF_A     = 8'h0c; // factory reference, analog supply
	localparam logic [7:0] REG_REF_B     = 8'h10; // factory reference, external pins
	localparam logic [7:0] REG_STATUS    = 8'h14; // load done
	// ==========================================================
	// information row addresses of factory values
	// ==========================================================
	localparam logic [23:0] INFO_REF_A_LO = 24'h1fc040;
	localparam logic [23:0] INFO_REF_A_HI = 24'h1fc041;
	localparam logic [23:0] INFO_REF_B_LO = 24'h1fc042;
	localparam logic [23:0] INFO_REF_B_HI = 24'h1fc043;
	localparam logic [23:0] OPTION_ADDR  = 24'hfffe0e; // nonvolatile option byte
	// ==========================================================
	// field layout and values
	// ==========================================================
	localparam int          RATE_W       = 3;
	localparam int          WINDOW_POS   = 3;
	localparam int          REF_W        = 12;
	localparam logic [1:0]  ROUTE_PIN    = 2'h0;
	localparam logic [1:0]  ROUTE_SER0   = 2'h1;
	localparam logic [1:0]  ROUTE_SER1   = 2'h2;
	localparam logic [7:0]  TRACE_ANSWER = 8'h00;
	localparam logic [7:0]  TRACE_CMD    = 8'h00; // command code, arbitrary
	// ==========================================================
	// loader states, gray along the path
	// ==========================================================
	typedef enum logic [2:0]
	{
		DIG_IDLE = 3'b000,
		DIG_OPT  = 3'b001,
		DIG_RALO = 3'b011,
		DIG_RAHI = 3'b010,
		DIG_RBLO = 3'b110,
		DIG_RBHI = 3'b111,
		DIG_DONE = 3'b101
	} dig_state_t;
endpackage : dig_pkg

// *** verilog/dig_nv_if.sv ***
`timescale 1ns/1ps
// nonvolatile read channel between loader and top
interface dig_nv_if;
	logic        req;  // read request
	logic [23:0] addr; // byte address
	logic [7:0]  data; // read data, one cycle later
	modport loader (output req, output addr, input data);
	modport top    (input req, input addr, output data);
endinterface : dig_nv_if

// *** verilog/dig_loader.sv ***
`timescale 1ns/1ps
// ==========================================================
// reset-time loader of option byte and factory values
// ==========================================================
module dig_loader
	import dig_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                clk_en,
	dig_nv_if.loader                 nv,
	output logic      [RATE_W-1:0]   rate,
	output logic                     window,
	output logic      [REF_W-1:0]    ref_a,
	output logic      [REF_W-1:0]    ref_b,
	output logic                     done
);
	dig_state_t        state;      // current step
	dig_state_t        next_state;
	logic [RATE_W-1:0] next_rate;
	logic              next_window;
	logic [REF_W-1:0]  next_ref_a;
	logic [REF_W-1:0]  next_ref_b;
	logic [7:0]        lo_byte;    // low byte held until high arrives
	logic [7:0]        next_lo_byte;

	// ==========================================================
	// next-state logic: IDLE through RBLO each issue a read, next one captures
	// ==========================================================
	always_comb
	begin
		next_state   = state;
		next_rate    = rate;
		next_window  = window;
		next_ref_a   = ref_a;
		next_ref_b   = ref_b;
		next_lo_byte = lo_byte;
		nv.req       = 1'b0;
		nv.addr      = OPTION_ADDR;
		unique case (state)
			DIG_IDLE:
			begin
				nv.req     = 1'b1;
				next_state = DIG_OPT;
			end
			DIG_OPT:
			begin
				// inverted encoding of option bits
				next_rate   = ~nv.data[RATE_W-1:0];
				next_window = ~nv.data[WINDOW_POS];
				nv.req      = 1'b1;
				nv.addr     = INFO_REF_A_LO;
				next_state  = DIG_RALO;
			end
			DIG_RALO:
			begin
				next_lo_byte = nv.data;
				nv.req       = 1'b1;
				nv.addr      = INFO_REF_A_HI;
				next_state   = DIG_RAHI;
			end
			DIG_RAHI:
			begin
				// right-justified: upper nibble of high byte dropped
				next_ref_a = {nv.data[3:0], lo_byte};
				nv.req     = 1'b1;
				nv.addr    = INFO_REF_B_LO;
				next_state = DIG_RBLO;
			end
			DIG_RBLO:
			begin
				next_lo_byte = nv.data;
				nv.req       = 1'b1;
				nv.addr      = INFO_REF_B_HI;
				next_state   = DIG_RBHI;
			end
			DIG_RBHI:
			begin
				next_ref_b = {nv.data[3:0], lo_byte};
				next_state = DIG_DONE;
			end
			DIG_DONE:
			begin
				next_state = DIG_DONE; // stays until next reset
			end
			default:
			begin
				next_state = DIG_IDLE; // illegal code restarts load
			end
		endcase
	end

	// ==========================================================
	// state registers
	// ==========================================================
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state   <= DIG_IDLE;
			rate    <= '0;
			window  <= 1'b0;
			ref_a   <= '0;
			ref_b   <= '0;
			lo_byte <= 8'h00;
			done    <= 1'b0;
		end
		else if (clk_en)
		begin
			state   <= next_state;
			rate    <= next_rate;
			window  <= next_window;
			ref_a   <= next_ref_a;
			ref_b   <= next_ref_b;
			lo_byte <= next_lo_byte;
			done    <= (next_state == DIG_DONE);
		end
	end
endmodule : dig_loader

// *** verilog/dig_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - reset loads watchdog rate and window from option
// - rate equals inverted low option bits
// - window bit is inverse of option bit3
// - trace buffer read command answers zero
// - supply-referenced bandgap value at C040/C041
// - pin-referenced bandgap value at C042/C043
// - stored values are 12-bit right-justified
// - route 01 feeds capture3 from serial0
// - route 10 feeds capture3 from serial1
// - any supply monitor low causes reset
// - io monitor ignored in reduced-power mode
// - processor held until load finishes
module dig_top
	import dig_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// nonvolatile memory read port, data in the same cycle as the request
	output logic             nv_req,
	output logic      [23:0] nv_addr,
	input  wire logic [7:0]  nv_rdata,
	// watchdog settings to the watchdog_control_register
	output logic      [2:0]  watchdog_rate_field,
	output logic             watchdog_window_bit,
	// background_debug_interface trace command
	input  wire logic        debug_cmd_valid,
	input  wire logic [7:0]  debug_cmd,
	output logic             debug_resp_valid,
	output logic      [7:0]  debug_resp,
	// capture routing
	input  wire logic        timer_channel3_pin,
	input  wire logic        serial0_receive_line,
	input  wire logic        serial1_receive_line,
	output logic             input_capture_channel3,
	// supply monitors
	input  wire logic        core_low,
	input  wire logic        flash_low,
	input  wire logic        io_supply_low,
	input  wire logic        voltage_regulator_reduced,
	output logic             low_voltage_reset,
	// processor hold during load
	output logic             cpu_hold
);
	// ==========================================================
	// internal state
	// ==========================================================
	dig_nv_if        nv ();           // loader channel
	logic [1:0]      route;           // capture_route_high_bit, capture_route_low_bit
	logic [1:0]      next_route;
	logic [31:0]     next_rdata;
	logic [2:0]      ld_rate;         // loaded rate
	logic            ld_window;       // loaded window mode
	logic [REF_W-1:0] ref_a;          // factory value, analog supply
	logic [REF_W-1:0] ref_b;          // factory value, reference pins
	logic            ld_done;         // load finished
	logic            next_cap;
	logic            next_lv_reset;
	logic            next_resp_valid;
	logic [7:0]      next_resp;

	// ==========================================================
	// loader
	// ==========================================================
	dig_loader u_loader
	(
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.nv      (nv.loader),
		.rate    (ld_rate),
		.window  (ld_window),
		.ref_a   (ref_a),
		.ref_b   (ref_b),
		.done    (ld_done)
	);
	assign nv.data = nv_rdata;

	// full byte-address decode shared by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ==========================================================
	// next values for registers and routed signals
	// ==========================================================
	always_comb
	begin
		next_route = route;
		if (reg_wr && hit(reg_addr, REG_ROUTE))
		begin
			next_route = reg_wdata[1:0];
		end
		// read data appear only in the cycle after the strobe
		next_rdata = 32'h00000000;
		if (reg_rd)
		begin
			if (hit(reg_addr, REG_ROUTE))
				next_rdata = {30'h0, route};
			else if (hit(reg_addr, REG_WATCHDOG))
				next_rdata = {28'h0, ld_window, ld_rate};
			else if (hit(reg_addr, REG_SUPPLY))
				next_rdata = {29'h0, low_voltage_reset, io_supply_low,
					voltage_regulator_reduced};
			else if (hit(reg_addr, REG_REF_A))
				next_rdata = {20'h0, ref_a};
			else if (hit(reg_addr, REG_REF_B))
				next_rdata = {20'h0, ref_b};
			else if (hit(reg_addr, REG_STATUS))
				next_rdata = {31'h0, ld_done};
			else
				next_rdata = 32'h00000000; // unmapped reads zero
		end
		// capture channel source; code 11 falls back to the pin
		unique case (route)
			ROUTE_SER0: next_cap = serial0_receive_line;
			ROUTE_SER1: next_cap = serial1_receive_line;
			default:    next_cap = timer_channel3_pin;
		endcase
		// io monitor masked in reduced-power regulator mode
		next_lv_reset = core_low | flash_low
			| (io_supply_low & ~voltage_regulator_reduced);
		// only the trace read gets an answer, always zero
		next_resp_valid = debug_cmd_valid && (debug_cmd == TRACE_CMD);
		next_resp       = TRACE_ANSWER;
	end

	// ==========================================================
	// registers; every output flopped
	// ==========================================================
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			route                  <= ROUTE_PIN;
			reg_rdata              <= 32'h00000000;
			input_capture_channel3 <= 1'b0;
			low_voltage_reset      <= 1'b0;
			debug_resp_valid       <= 1'b0;
			debug_resp             <= 8'h00;
			cpu_hold               <= 1'b1;
			nv_req                 <= 1'b0;
			nv_addr                <= 24'h000000;
			watchdog_rate_field    <= 3'h0;
			watchdog_window_bit    <= 1'b0;
		end
		else if (clk_en)
		begin
			route                  <= next_route;
			reg_rdata              <= next_rdata;
			input_capture_channel3 <= next_cap;
			low_voltage_reset      <= next_lv_reset;
			debug_resp_valid       <= next_resp_valid;
			debug_resp             <= next_resp;
			cpu_hold               <= ~ld_done;
			// request registered here, so the loader sees data one cycle later still
			nv_req                 <= nv.req;
			nv_addr                <= nv.addr;
			watchdog_rate_field    <= ld_rate;
			watchdog_window_bit    <= ld_window;
		end
	end
endmodule : dig_top

// *** dv/dig_nv_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// nonvolatile option and information row storage
// ==========================================================
module dig_nv_model
	import dig_pkg::*;
#(
	parameter logic [7:0]	REF_A_LO = 8'h34,
	parameter logic [7:0]	REF_A_HI = 8'hf2,
	parameter logic [7:0]	REF_B_LO = 8'hcd,
	parameter logic [7:0]	REF_B_HI = 8'h5a
)
(
	input wire logic	clk,
	input wire logic	nv_req,
	input wire logic [23:0]	nv_addr,
	input wire logic [7:0]	option,
	output logic [7:0]	nv_rdata
);
	logic [7:0]	last;      // last byte handed out
	logic [7:0]	next_last; // next of last
	logic [7:0]	word;      // byte at the address
	// answer in the request cycle; idle bus shows junk
	always_comb
	begin
		case (nv_addr)
			OPTION_ADDR:	word = option;
			INFO_REF_A_LO:	word = REF_A_LO;
			INFO_REF_A_HI:	word = REF_A_HI;
			INFO_REF_B_LO:	word = REF_B_LO;
			INFO_REF_B_HI:	word = REF_B_HI;
			default:	word = ~last;
		endcase
		next_last = nv_req ? word : last;
		nv_rdata = nv_req ? word : ~last;
	end
	// remember what was last served
	always_ff @(posedge clk)
		last <= next_last;
endmodule : dig_nv_model

// *** dv/dig_top_chk.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker
// ==========================================================
module dig_top_chk
	import dig_pkg::*;
(
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	nv_req,
	input wire logic [23:0]	nv_addr,
	input wire logic [7:0]	nv_rdata,
	input wire logic [2:0]	watchdog_rate_field,
	input wire logic	watchdog_window_bit,
	input wire logic	debug_cmd_valid,
	input wire logic [7:0]	debug_cmd,
	input wire logic	debug_resp_valid,
	input wire logic [7:0]	debug_resp,
	input wire logic	core_low,
	input wire logic	flash_low,
	input wire logic	io_supply_low,
	input wire logic	voltage_regulator_reduced,
	input wire logic	low_voltage_reset,
	input wire logic	cpu_hold
);
	logic [7:0]	opt;      // option byte seen on the bus
	logic [7:0]	next_opt; // next of opt
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// capture the option byte as it is served
	always_comb
	begin
		next_opt = opt;
		if (nv_req && nv_addr == OPTION_ADDR)
			next_opt = nv_rdata;
	end
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			opt <= 8'h00;
		else
			opt <= next_opt;
	property p_supply_reset; $past(reset_n) |-> low_voltage_reset == $past(core_low |
		flash_low | (io_supply_low & !voltage_regulator_reduced)); endproperty
	a_supply_reset: assert property (p_supply_reset) else $error("supply reset wrong");
	property p_io_off; voltage_regulator_reduced && !core_low && !flash_low
		|=> !low_voltage_reset; endproperty
	a_io_off: assert property (p_io_off) else $error("io monitor not ignored");
	property p_dbg; debug_cmd_valid && debug_cmd == TRACE_CMD
		|=> debug_resp_valid && debug_resp == TRACE_ANSWER; endproperty
	a_dbg: assert property (p_dbg) else $error("trace answer wrong");
	property p_rate; !cpu_hold |-> watchdog_rate_field == ~opt[2:0]; endproperty
	a_rate: assert property (p_rate) else $error("rate not inverted option");
	property p_window; !cpu_hold |-> watchdog_window_bit == !opt[WINDOW_POS]; endproperty
	a_window: assert property (p_window) else $error("window not inverted");
	property p_hold; nv_req |-> cpu_hold; endproperty
	a_hold: assert property (p_hold) else $error("cpu free during load");
	property p_order; nv_req && nv_addr == OPTION_ADDR |=> nv_addr == INFO_REF_A_LO
		##1 nv_addr == INFO_REF_A_HI ##1 nv_addr == INFO_REF_B_LO
		##1 nv_addr == INFO_REF_B_HI; endproperty
	a_order: assert property (p_order) else $error("load order wrong");
	property p_end; nv_req && nv_addr == INFO_REF_B_HI |-> ##[1:8] !cpu_hold; endproperty
	a_end: assert property (p_end) else $error("cpu hold stuck");
	c_load: cover property ($fell(cpu_hold));
	c_dbg: cover property (debug_resp_valid);
	c_supply_reset: cover property (low_voltage_reset);
endmodule : dig_top_chk
bind dig_top dig_top_chk dig_top_chk_inst (.clk(clk), .reset_n(reset_n),
	.nv_req(nv_req), .nv_addr(nv_addr), .nv_rdata(nv_rdata),
	.watchdog_rate_field(watchdog_rate_field), .watchdog_window_bit(watchdog_window_bit),
	.debug_cmd_valid(debug_cmd_valid), .debug_cmd(debug_cmd),
	.debug_resp_valid(debug_resp_valid), .debug_resp(debug_resp),
	.core_low(core_low), .flash_low(flash_low), .io_supply_low(io_supply_low),
	.voltage_regulator_reduced(voltage_regulator_reduced),
	.low_voltage_reset(low_voltage_reset), .cpu_hold(cpu_hold));

// *** dv/test_dig_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench for the integration glue
// ==========================================================
module test_dig_top
	import dig_pkg::*;
;
	logic	clk = 1'b0;
	logic	reset_n = 1'b0;
	logic [7:0]	reg_addr = 8'h00;
	logic [31:0]	reg_wdata = 32'h0;
	logic [31:0]	reg_rdata;
	logic	reg_wr = 1'b0;
	logic	reg_rd = 1'b0;
	logic	nv_req, window, drv, cap3, lv_rst, hold;
	logic	ce = 1'b1;        // clock enable, dropped once to freeze state
	logic [23:0]	nv_addr;
	logic [7:0]	nv_rdata, debug_resp;
	logic [7:0]	option = 8'h00;   // option byte in storage
	logic [7:0]	debug_cmd = 8'h00;
	logic	dcv = 1'b0;       // debug command strobe
	logic [2:0]	rate;
	logic [2:0]	rx = 3'h0;        // pin, serial0, serial1
	logic [3:0]	sup = 4'h0;       // core, flash, io, reduced
	int	err_count = 0;
	int	checks_done = 0;
	dig_top dig_top_inst (.clk(clk), .reset_n(reset_n), .clk_en(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.nv_req(nv_req), .nv_addr(nv_addr), .nv_rdata(nv_rdata),
		.watchdog_rate_field(rate), .watchdog_window_bit(window), .debug_cmd_valid(dcv),
		.debug_cmd(debug_cmd), .debug_resp_valid(drv), .debug_resp(debug_resp),
		.timer_channel3_pin(rx[0]), .serial0_receive_line(rx[1]),
		.serial1_receive_line(rx[2]), .input_capture_channel3(cap3), .core_low(sup[0]),
		.flash_low(sup[1]), .io_supply_low(sup[2]), .voltage_regulator_reduced(sup[3]),
		.low_voltage_reset(lv_rst), .cpu_hold(hold));
	dig_nv_model dig_nv_model_inst (.clk(clk), .nv_req(nv_req), .nv_addr(nv_addr),
		.option(option), .nv_rdata(nv_rdata));
	// ==========================================================
	// helpers
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// reset, then wait a bounded time for the load
	task automatic boot(input int n);
		reset_n <= 1'b0;
		repeat (n) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 40 && hold !== 1'b0; i++)
			@(posedge clk);
		chk(hold, 1'b0);
	endtask : boot
	task automatic test_done();
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// ==========================================================
	// clock, watchdog and tests
	// ==========================================================
	initial
		forever #50 clk = ~clk;
	initial
	begin
		#500000;
		err_count++;
		test_done();
	end
	initial
	begin
		boot(16);
		rd(REG_REF_A, 32'h234);
		rd(REG_REF_B, 32'hacd);
		rd(8'h3c, 32'h0);
		rd(REG_STATUS, 32'h1);
		// every option code, upper bits as junk
		for (int o = 0; o < 16; o++)
		begin
			logic [3:0] inv;
			inv = ~o[3:0];
			option <= {4'ha, o[3:0]};
			boot(2);
			chk(rate, inv[2:0]);
			chk(window, inv[3]);
			rd(REG_WATCHDOG, {28'h0, inv});
		end
		// each routing code against each input pattern
		for (int r = 0; r < 4; r++)
		begin
			wr(REG_ROUTE, r);
			rd(REG_ROUTE, r);
			for (int p = 0; p < 8; p++)
			begin
				@(posedge clk);
				rx <= p[2:0];
				repeat (2) @(posedge clk);
				#1 chk(cap3, p[(r == 1) ? 1 : (r == 2) ? 2 : 0]);
			end
		end
		// with the enable low a write is not taken; route stays at 11
		ce <= 1'b0;
		wr(REG_ROUTE, 32'h0);
		ce <= 1'b1;
		rd(REG_ROUTE, 32'h3);
		// every supply monitor combination
		for (int s = 0; s < 16; s++)
		begin
			@(posedge clk);
			sup <= s[3:0];
			repeat (2) @(posedge clk);
			#1 chk(lv_rst, s[0] | s[1] | (s[2] & !s[3]));
			rd(REG_SUPPLY, {29'h0, s[0] | s[1] | (s[2] & !s[3]), s[2], s[3]});
		end
		@(posedge clk);
		dcv <= 1'b1;
		debug_cmd <= TRACE_CMD;
		@(posedge clk);
		debug_cmd <= 8'h5a;
		#1 chk({drv, debug_resp}, {1'b1, TRACE_ANSWER});
		@(posedge clk);
		dcv <= 1'b0;
		#1 chk(drv, 1'b0);
		test_done();
	end
endmodule : test_dig_top
